// ==== verilog/cat_top.sv ====
// Charger alert enables, alert latching and thermal charge-current cap.
//
// Overview of operation
// RQ1 - Alert on missing battery when enabled.
// RQ2 - Alert on shorted battery when enabled.
// RQ3 - Six-bit charge-status alert enable register.
// RQ4 - Alert on current-limit flag when enabled.
// RQ5 - Dropout without regulating loop sets current-limit flag.
// RQ6 - Alert while thermal regulation cuts current.
// RQ7 - Alert when undervoltage loop takes control.
// RQ8 - Alert when input-current loop takes control.
// RQ9 - Alert when constant-current loop takes control.
// RQ10 - Alert when constant-voltage loop takes control.
// RQ11 - Signed thermal start threshold, default 17897.
// RQ12 - Signed thermal end threshold, default 18130.
// RQ13 - Cap falls linearly 31 to 0.
// RQ14 - Config register; top bit suspends charging.
// RQ15 - Host sets suspend carefully; deadlock risk.
// RQ16 - Thirteen-bit charger-state alert enable register.
// RQ17 - Latch enabled events; alert until cleared.
`timescale 1ns/1ps
`include "cat_defs.svh"
module cat_top
   import cat_pkg::*;
#(
   parameter int TEMP_W = 16
)
(
   input wire logic mclk,
   input wire logic resetn,
   // Register port, one command code per access.
   input wire logic [7:0] reg_cmd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // Charger conditions, levels.
   input wire logic bat_missing_fault,
   input wire logic bat_short_fault,
   input wire logic sense_over_limit,
   input wire logic regulator_dropout,
   input wire logic vin_uvcl_active,
   input wire logic iin_limit_active,
   input wire logic cc_loop_active,
   input wire logic cv_loop_active,
   // Die temperature and requested charge-current code.
   input wire logic signed [TEMP_W-1:0] die_temp,
   input wire logic [4:0] charge_current_req,
   // Host clears latched events, one bit each.
   input wire logic [8:0] event_clear,
   // Results.
   output logic [8:0] event_status_q,
   output logic smbalert_n_q,
   output logic ilim_active_q,
   output logic thermal_active_q,
   output logic [4:0] icharge_code_q,
   output logic suspend_charger_q
);

   if (TEMP_W != 16) begin : g_chk
      $error("cat_top registers hold a 16-bit die temperature");
   end

   // Every register must fit the 16-bit data port, and the suspend
   // field must sit inside the configuration register.
   if (`CAT_STATE_EN_W > 16 || `CAT_STATUS_EN_W > 16 || `CAT_CONFIG_W > 16 ||
       `CAT_CFG_SUSPEND >= `CAT_CONFIG_W) begin : g_chk_regs
      $error("cat_top register fields do not fit the data port");
   end

   // Timing at a glance, counted in mclk edges from the edge that
   // first samples an input change:
   //  - a register write lands at that edge and reads back at once;
   //  - read data and its valid pulse stand one cycle after the strobe;
   //  - a fault or loop input latches at that edge and shows on the
   //    status and alert outputs one edge later;
   //  - the current-limit and thermal flags are registered first, so
   //    their events latch one edge later than the raw inputs do;
   //  - the suspend output follows the configuration bit by one edge,
   //    and its event follows the suspend output by one more edge.
   // Events are caught on the rising edge of a condition, so a host
   // that enables an alert while its condition already holds sees no
   // alert until the condition drops and returns.

   // Register storage. Each register keeps only its own width; bits
   // above it are dropped on write and read back as zero.
   logic [`CAT_STATE_EN_W-1:0] state_en_q;
   logic [`CAT_STATUS_EN_W-1:0] status_en_q;
   logic [15:0] th_start_q;
   logic [15:0] th_end_q;
   logic [`CAT_CONFIG_W-1:0] config_q;

   // Host write request gathered into one carrier, which keeps the
   // command code and data of one access side by side.
   cat_wr_t wr;

   // Read path.
   logic [15:0] rdata_d;

   // Condition and enable vectors for the latches, both in the bit
   // order of the status output.
   cat_cond_t cond;
   cat_cond_t enable;
   logic [8:0] status;

   // Thermal path.
   logic [4:0] th_cap;
   logic loop_regulating;

   // One write hit per register; at most one is true per access.
   logic hit_state_en;
   logic hit_status_en;
   logic hit_th_start;
   logic hit_th_end;
   logic hit_config;

   assign wr.cmd = reg_cmd;
   assign wr.data = reg_wdata;

   // The command code of a write is decoded once, in one place, so an
   // unmapped code can never reach any register.
   assign hit_state_en = reg_wr && (wr.cmd == `CAT_CMD_STATE_EN);
   assign hit_status_en = reg_wr && (wr.cmd == `CAT_CMD_STATUS_EN);
   assign hit_th_start = reg_wr && (wr.cmd == `CAT_CMD_TH_START);
   assign hit_th_end = reg_wr && (wr.cmd == `CAT_CMD_TH_END);
   assign hit_config = reg_wr && (wr.cmd == `CAT_CMD_CONFIG);

   // Charger-state alert enable register. All thirteen bits are kept;
   // only the two battery bits and the suspend bit act in this block.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         state_en_q <= `CAT_STATE_EN_RST; // RQ16
      else if (hit_state_en)
         state_en_q <= wr.data[`CAT_STATE_EN_W-1:0]; // RQ16
   end

   // Charge-status alert enable register, one enable bit for each
   // charge-status condition.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         status_en_q <= `CAT_STATUS_EN_RST; // RQ3
      else if (hit_status_en)
         status_en_q <= wr.data[`CAT_STATUS_EN_W-1:0]; // RQ3
   end

   // Thermal regulation start threshold, signed. A write acts on the
   // cap in the very next cycle.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         th_start_q <= `CAT_TH_START_RST; // RQ11
      else if (hit_th_start)
         th_start_q <= wr.data; // RQ11
   end

   // Thermal regulation end threshold, signed. Nothing orders the two
   // thresholds; an inverted pair turns the slope into a hard step.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         th_end_q <= `CAT_TH_END_RST; // RQ12
      else if (hit_th_end)
         th_end_q <= wr.data; // RQ12
   end

   // Configuration register; only the suspend bit acts here.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         config_q <= `CAT_CONFIG_RST; // RQ14
      else if (hit_config)
         config_q <= wr.data[`CAT_CONFIG_W-1:0]; // RQ14
   end

   // Read multiplexer; unmapped codes and unused high bits read zero.
   // It looks at the command code alone, so a write and a read in the
   // same cycle return the value from before the write.
   always_comb
   begin
      rdata_d = 16'h0000;
      case (reg_cmd)
         `CAT_CMD_STATE_EN:
            rdata_d = 16'(state_en_q);
         `CAT_CMD_STATUS_EN:
            rdata_d = 16'(status_en_q);
         `CAT_CMD_TH_START:
            rdata_d = th_start_q;
         `CAT_CMD_TH_END:
            rdata_d = th_end_q;
         `CAT_CMD_CONFIG:
            rdata_d = 16'(config_q);
         default:
            rdata_d = 16'h0000;
      endcase
   end

   // Read data is presented one cycle after the read strobe and holds
   // until the next read, so a slow host may still pick it up late.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata_q <= 16'h0000;
      else if (reg_rd)
         reg_rdata_q <= rdata_d;
   end

   // Read valid is a one-cycle pulse that answers each read strobe.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         reg_rvalid_q <= 1'b0;
      else
         reg_rvalid_q <= reg_rd;
   end

   // Suspend bit drives the charger through one flop after the register.
   // Suspending may starve a battery-powered bus of its supply.
   // The host must keep a way to clear it that needs no battery.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         suspend_charger_q <= 1'b0;
      else
         suspend_charger_q <= config_q[`CAT_CFG_SUSPEND]; // RQ14
   end

   // A loop that regulates rules out an unregulated dropout.
   // Dropout with a loop in control is normal and raises nothing.
   assign loop_regulating = vin_uvcl_active | iin_limit_active |
                            cc_loop_active | cv_loop_active;

   // Safety current-limit flag: sense over threshold, or dropout
   // with no feedback loop in control.
   // Either cause points at a board fault rather than a normal
   // charge phase, so the flag is kept as a plain level.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         ilim_active_q <= 1'b0;
      else
         ilim_active_q <= sense_over_limit | // RQ4
                          (regulator_dropout & ~loop_regulating); // RQ5
   end

   // Thermal cap from die temperature and the two thresholds.
   // The cap is combinational; it is registered below together with
   // the request, so a die-temperature change and a new request line up.
   cat_thermal_limit #(
      .TEMP_W(TEMP_W)
   ) u_thermal (
      .die_temp(die_temp),
      .start_temp($signed(th_start_q)),
      .end_temp($signed(th_end_q)),
      .cap(th_cap)
   );

   // Charge-current code is the lesser of request and cap, so the cap
   // can only pull the charger down, never push it above the request.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         icharge_code_q <= 5'h00;
      else if (th_cap < charge_current_req)
         icharge_code_q <= th_cap; // RQ13
      else
         icharge_code_q <= charge_current_req;
   end

   // Thermal regulation is active while the cap is what holds the
   // code down; a cap equal to the request does not count.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         thermal_active_q <= 1'b0;
      else
         thermal_active_q <= (th_cap < charge_current_req); // RQ6
   end

   // Conditions in latch order. The thermal and current-limit ones are
   // the registered flags, so their events lag the raw inputs by one
   // more cycle.
   always_comb
   begin
      cond.bat_short = bat_short_fault; // RQ2
      cond.bat_missing = bat_missing_fault; // RQ1
      cond.cv = cv_loop_active; // RQ10
      cond.cc = cc_loop_active; // RQ9
      cond.iin = iin_limit_active; // RQ8
      cond.uvcl = vin_uvcl_active; // RQ7
      cond.thermal = thermal_active_q; // RQ6
      cond.ilim = ilim_active_q; // RQ4
      cond.suspended = suspend_charger_q;
   end

   // Enables taken from the two enable registers. Charger-state bit 8
   // guards the suspend event; enabling late does not catch a level
   // that is already held.
   always_comb
   begin
      enable.bat_short = state_en_q[`CAT_ST_BAT_SHORT]; // RQ2
      enable.bat_missing = state_en_q[`CAT_ST_BAT_MISSING]; // RQ1
      enable.cv = status_en_q[`CAT_CS_CV]; // RQ10
      enable.cc = status_en_q[`CAT_CS_CC]; // RQ9
      enable.iin = status_en_q[`CAT_CS_IIN]; // RQ8
      enable.uvcl = status_en_q[`CAT_CS_UVCL]; // RQ7
      enable.thermal = status_en_q[`CAT_CS_THERMAL]; // RQ6
      enable.ilim = status_en_q[`CAT_CS_ILIM]; // RQ4
      enable.suspended = state_en_q[`CAT_ST_SUSPENDED];
   end

   // Sticky event latches. A new event in the clearing cycle wins, so
   // no event is ever lost to a clear.
   cat_event_latch #(
      .N(9)
   ) u_events (
      .mclk(mclk),
      .resetn(resetn),
      .cond(cond),
      .enable(enable),
      .clear(event_clear),
      .status_q(status)
   );

   // Latched events are shown to the host one cycle after they set.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         event_status_q <= 9'h000;
      else
         event_status_q <= status; // RQ17
   end

   // The alert line stays low while any latched event waits for the
   // host; it is taken from the same latches as the status, so the
   // two outputs never disagree.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         smbalert_n_q <= 1'b1;
      else
         smbalert_n_q <= ~(|status); // RQ17
   end

endmodule : cat_top

// ==== verilog/cat_defs.svh ====
// Command codes, field positions, widths and reset values of the alert block.
`ifndef CAT_DEFS_SVH
`define CAT_DEFS_SVH

// Command codes of the registers.
`define CAT_CMD_STATE_EN 8'h0E
`define CAT_CMD_STATUS_EN 8'h0F
`define CAT_CMD_TH_START 8'h10
`define CAT_CMD_TH_END 8'h11
`define CAT_CMD_CONFIG 8'h14

// Register widths.
`define CAT_STATE_EN_W 13
`define CAT_STATUS_EN_W 6
`define CAT_CONFIG_W 6

// Reset values.
`define CAT_STATE_EN_RST 13'h0000
`define CAT_STATUS_EN_RST 6'h00
`define CAT_TH_START_RST 16'h45E9
`define CAT_TH_END_RST 16'h46D2
`define CAT_CONFIG_RST 6'h00

// Fields of the charger-state enable register.
`define CAT_ST_BAT_SHORT 0
`define CAT_ST_BAT_MISSING 1
`define CAT_ST_SUSPENDED 8

// Fields of the charge-status enable register.
`define CAT_CS_CV 0
`define CAT_CS_CC 1
`define CAT_CS_IIN 2
`define CAT_CS_UVCL 3
`define CAT_CS_THERMAL 4
`define CAT_CS_ILIM 5

// Field of the configuration register.
`define CAT_CFG_SUSPEND 5

// Charge-current code at full scale.
`define CAT_ICHG_FULL 5'h1F

`endif

// ==== verilog/cat_pkg.sv ====
// Types shared by the alert block modules.
package cat_pkg;

   // Conditions that can raise an alert, one bit each.
   typedef struct packed {
      logic suspended;
      logic ilim;
      logic thermal;
      logic uvcl;
      logic iin;
      logic cc;
      logic cv;
      logic bat_missing;
      logic bat_short;
   } cat_cond_t;

   // One register write from the host port.
   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] data;
   } cat_wr_t;

endpackage : cat_pkg

// ==== verilog/cat_event_latch.sv ====
// Sticky per-event latches set on a rising, enabled condition.
`timescale 1ns/1ps
module cat_event_latch
   import cat_pkg::*;
#(
   parameter int N = 9
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [N-1:0] cond,
   input wire logic [N-1:0] enable,
   input wire logic [N-1:0] clear,
   output logic [N-1:0] status_q
);

   logic [N-1:0] cond_q;

   if (N < 1) begin : g_chk
      $error("cat_event_latch needs at least one event");
   end

   // Each event remembers its condition and latches its rising edge.
   for (genvar i = 0; i < N; i++) begin : g_ev
      always_ff @(posedge mclk or negedge resetn)
      begin
         if (!resetn) begin
            cond_q[i] <= 1'b0;
            status_q[i] <= 1'b0;
         end else begin
            cond_q[i] <= cond[i];
            // A new event in the clearing cycle wins over the clear.
            if (cond[i] && !cond_q[i] && enable[i])
               status_q[i] <= 1'b1; // RQ17
            else if (clear[i])
               status_q[i] <= 1'b0;
         end
      end
   end

endmodule : cat_event_latch

// ==== verilog/cat_thermal_limit.sv ====
// Linear charge-current cap between two signed die-temperature thresholds.
`timescale 1ns/1ps
`include "cat_defs.svh"
module cat_thermal_limit
   import cat_pkg::*;
#(
   parameter int TEMP_W = 16
)
(
   input wire logic signed [TEMP_W-1:0] die_temp,
   input wire logic signed [TEMP_W-1:0] start_temp,
   input wire logic signed [TEMP_W-1:0] end_temp,
   output logic [4:0] cap
);

   logic [TEMP_W:0] num;
   logic [TEMP_W:0] span;
   logic [TEMP_W+5:0] prod;
   logic [TEMP_W+5:0] quo;

   if (TEMP_W < 2) begin : g_chk
      $error("cat_thermal_limit needs a temperature of two bits or more");
   end

   // Full scale below start, zero past end, a straight line between.
   always_comb
   begin
      num = '0;
      span = '0;
      prod = '0;
      quo = '0;
      cap = `CAT_ICHG_FULL;
      if (die_temp <= start_temp)
         cap = `CAT_ICHG_FULL; // RQ13
      else if (die_temp >= end_temp)
         cap = 5'h00; // RQ13
      else begin
         // Here start < temp < end, so both differences are positive.
         num = (TEMP_W+1)'(end_temp) - (TEMP_W+1)'(die_temp);
         span = (TEMP_W+1)'(end_temp) - (TEMP_W+1)'(start_temp);
         prod = (TEMP_W+6)'(num) * (TEMP_W+6)'(`CAT_ICHG_FULL);
         quo = prod / (TEMP_W+6)'(span);
         cap = quo[4:0]; // RQ13
      end
   end

endmodule : cat_thermal_limit

// ==== testbench/cat_top_chk.sv ====
// Port checker of the alert block.
`timescale 1ns/1ps
module cat_top_chk
   import cat_pkg::*;
#(
   parameter int TEMP_W = 16
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [7:0] reg_cmd,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rvalid_q,
   input wire logic bat_missing_fault,
   input wire logic bat_short_fault,
   input wire logic sense_over_limit,
   input wire logic regulator_dropout,
   input wire logic vin_uvcl_active,
   input wire logic iin_limit_active,
   input wire logic cc_loop_active,
   input wire logic cv_loop_active,
   input wire logic [4:0] charge_current_req,
   input wire logic [8:0] event_status_q,
   input wire logic smbalert_n_q,
   input wire logic ilim_active_q,
   input wire logic thermal_active_q,
   input wire logic [4:0] icharge_code_q,
   input wire logic suspend_charger_q
);
   logic ilim_raw;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Current-limit cause: over sense, or dropout with no loop in control.
   assign ilim_raw = sense_over_limit | (regulator_dropout & ~(vin_uvcl_active
      | iin_limit_active | cc_loop_active | cv_loop_active));
   // Register port, alert line and flags.
   a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
      else $error("read not answered");
   a_rvalid_single: assert property (!reg_rd |=> !reg_rvalid_q)
      else $error("spurious read valid");
   a_alert_level: assert property (smbalert_n_q == (event_status_q == 9'h000))
      else $error("alert differs from latches");
   a_cv_cause: assert property ($rose(event_status_q[2]) |-> $past(cv_loop_active, 2))
      else $error("cv event without cause");
   a_short_cause: assert property ($rose(event_status_q[0]) |-> $past(bat_short_fault, 2))
      else $error("short event without cause");
   a_missing_cause: assert property ($rose(event_status_q[1]) |-> $past(bat_missing_fault, 2))
      else $error("missing event without cause");
   a_ilim_flag: assert property ($past(resetn) |-> ilim_active_q == $past(ilim_raw))
      else $error("current-limit flag wrong");
   a_thermal_flag: assert property ($past(resetn)
      |-> thermal_active_q == (icharge_code_q != $past(charge_current_req)))
      else $error("thermal flag wrong");
   a_code_bound: assert property (icharge_code_q <= $past(charge_current_req))
      else $error("charge code above request");
   a_suspend_write: assert property ($changed(suspend_charger_q)
      |-> $past(reg_wr, 2) && $past(reg_cmd, 2) == 8'h14)
      else $error("suspend changed without write");
   c_read: cover property (reg_rvalid_q);
   c_alert: cover property ($fell(smbalert_n_q));
   c_thermal: cover property (thermal_active_q && icharge_code_q != 5'h00);
endmodule : cat_top_chk
bind cat_top cat_top_chk #(.TEMP_W(TEMP_W)) i_cat_top_chk (.*);

// ==== testbench/cat_host_model.sv ====
// Host model that makes register writes and reads.
`timescale 1ns/1ps
module cat_host_model
(
   input wire logic mclk,
   output logic [7:0] reg_cmd,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata_q,
   input wire logic reg_rvalid_q
);
   // Idle bus at time zero.
   initial
   begin
      reg_cmd = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
   end
   // One write; released data is inverted so stale values never match.
   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      @(posedge mclk);
      reg_cmd <= cmd;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~data;
   endtask : wr
   // One read; the answer stands one cycle after the taking edge.
   task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
      @(posedge mclk);
      reg_cmd <= cmd;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      data = reg_rvalid_q ? reg_rdata_q : 16'hXXXX;
   endtask : rd
endmodule : cat_host_model

// ==== testbench/cat_top_bench.sv ====
// Self-checking bench of the alert block.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module cat_top_bench;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_cmd;
   logic reg_wr, reg_rd, reg_rvalid_q;
   logic [15:0] reg_wdata, reg_rdata_q, rdv;
   logic [7:0] lvl = 8'h00;
   logic signed [15:0] die_temp = 16'sh0000;
   logic [4:0] req = 5'h1F;
   logic [8:0] clr = 9'h000;
   logic [8:0] w_status, s_status;
   logic w_alert, w_ilim, w_therm, w_susp, s_alert, s_ilim, s_therm, s_susp;
   logic [4:0] w_code, s_code;
   logic [31:0] rng = 32'h87D7;
   int n_fail = 0;
   int compares = 0;
   // Clock of 100 ns period.
   always #50 mclk = ~mclk;
   // Outputs are taken at the falling edge, where they are settled.
   always @(negedge mclk)
   begin
      {s_status, s_alert, s_ilim, s_therm, s_code, s_susp} <=
         {w_status, w_alert, w_ilim, w_therm, w_code, w_susp};
   end
   cat_top i_cat_top (.mclk(mclk), .resetn(resetn), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q), .bat_short_fault(lvl[0]), .bat_missing_fault(lvl[1]),
      .cv_loop_active(lvl[2]), .cc_loop_active(lvl[3]), .iin_limit_active(lvl[4]),
      .vin_uvcl_active(lvl[5]), .sense_over_limit(lvl[6]), .regulator_dropout(lvl[7]),
      .die_temp(die_temp), .charge_current_req(req), .event_clear(clr),
      .event_status_q(w_status), .smbalert_n_q(w_alert), .ilim_active_q(w_ilim),
      .thermal_active_q(w_therm), .icharge_code_q(w_code), .suspend_charger_q(w_susp));
   cat_host_model i_cat_host_model (.mclk(mclk), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q));
   // Random source of the bench.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Expected cap: full scale below start, zero from end, linear between.
   function automatic logic [4:0] exp_cap(input int t, input int s, input int e);
      if (t <= s) return 5'h1F;
      if (t >= e) return 5'h00;
      return 5'((e - t) * 31 / (e - s));
   endfunction : exp_cap
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
   endtask : step
   // Pulse every clear bit for one cycle.
   task automatic clear_all;
      clr <= 9'h1FF;
      step(1);
      clr <= 9'h000;
      step(2);
   endtask : clear_all
   task automatic complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   // Cuts a hang short.
   initial
   begin
      step(20000);
      n_fail++;
      complete_run();
   end
   // Main sequence.
   initial
   begin
      logic [7:0] cmds [6] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h14, 8'h20};
      logic [15:0] dflt [6] = '{16'h0, 16'h0, 16'h45E9, 16'h46D2, 16'h0, 16'h0};
      logic [15:0] msk [6] = '{16'h1FFF, 16'h3F, 16'hFFFF, 16'hFFFF, 16'h3F, 16'h0};
      int k, t;
      logic [4:0] c, q;
      step(6);
      resetn <= 1'b1;
      for (k = 0; k < 6; k++)
      begin
         i_cat_host_model.rd(cmds[k], rdv);
         `CHK(rdv, dflt[k])
      end
      for (k = 0; k < 6; k++)
      begin
         rng = xs(rng);
         i_cat_host_model.wr(cmds[k], rng[15:0]);
         i_cat_host_model.rd(cmds[k], rdv);
         `CHK(rdv, rng[15:0] & msk[k])
         i_cat_host_model.wr(cmds[k], dflt[k]);
      end
      clear_all();
      $display("test registers done");
      lvl <= 8'hFF;
      step(4);
      `CHK(s_status, 9'h000)
      lvl <= 8'h00;
      i_cat_host_model.wr(8'h0F, 16'h003F);
      i_cat_host_model.wr(8'h0E, 16'h0103);
      for (k = 0; k < 8; k++)
      begin
         lvl <= 8'h01 << k;
         step(4);
         `CHK(s_status, 9'h001 << ((k < 6) ? k : 7))
         `CHK(s_alert, 1'b0)
         if (k > 5) `CHK(s_ilim, 1'b1)
         clear_all();
         `CHK({s_status, s_alert}, 10'h001)
         lvl <= 8'h00;
         step(2);
      end
      // A clear pulse in the very cycle of a new event must not lose it.
      clr <= 9'h004;
      lvl <= 8'h04;
      step(1);
      clr <= 9'h000;
      step(3);
      `CHK(s_status, 9'h004)
      clear_all();
      lvl <= 8'h00;
      step(2);
      $display("test events done");
      for (k = 0; k < 24; k++)
      begin
         rng = xs(rng);
         t = (k == 0) ? 17897 : (k == 1) ? 18130 : 17877 + int'(rng[8:0] % 274);
         q = rng[20:16];
         c = exp_cap(t, 17897, 18130);
         req <= q;
         die_temp <= 16'(t);
         step(3);
         `CHK(s_code, (c < q) ? c : q)
         `CHK(s_therm, c < q)
      end
      req <= 5'h1F;
      die_temp <= 16'sd17897;
      step(3);
      clear_all();
      die_temp <= 16'sd18130;
      step(4);
      `CHK(s_status, 9'h040)
      clear_all();
      $display("test thermal done");
      i_cat_host_model.wr(8'h14, 16'h0020);
      step(4);
      `CHK({s_susp, s_status}, 10'h300)
      i_cat_host_model.wr(8'h14, 16'h0000);
      step(3);
      `CHK(s_susp, 1'b0)
      $display("test suspend done");
      complete_run();
   end
endmodule : cat_top_bench
